// ==== src/lbd_pkg.sv ====
package lbd_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS   = 8;      // 125 MHz system clock
	localparam int unsigned SLOT_TIME_NS    = 250000; // Duty slot, 250 us
	localparam int unsigned STEP_TIME_MS    = 64;     // Pattern step, 64 ms
	localparam int unsigned FRAME_TIME_MS   = 8;      // Duty frame, 8 ms
	localparam int unsigned SLOT_CYC_DEF    = SLOT_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned SLOTS_PER_FRAME = 32;
	localparam int unsigned SLOTS_PER_STEP  = (STEP_TIME_MS * 1000000) / SLOT_TIME_NS;

	// Register offsets
	localparam logic [7:0] ADDR_REPEAT_PERIOD = 8'h4c;
	localparam logic [7:0] ADDR_DUTY_CYCLE    = 8'h4d;
	localparam logic [7:0] ADDR_ON_DURATION   = 8'h4e;

	// Field widths and reset values
	localparam int unsigned PERIOD_W    = 7;
	localparam int unsigned DUTY_W      = 5;
	localparam int unsigned ONDUR_W     = 5;
	localparam logic [6:0]  PERIOD_RST  = 7'h00;
	localparam logic [4:0]  DUTY_RST    = 5'h00;
	localparam logic [4:0]  ONDUR_RST   = 5'h00;
	localparam logic [7:0]  RDATA_RST   = 8'h00;

	// Pattern phase
	typedef enum logic {
		PH_LIT,
		PH_DARK
	} lbd_phase_t;

	// Step-length field widened to the step counter width
	function automatic logic [7:0] lbd_step_len(input logic [6:0] field);
		lbd_step_len = {1'b0, field};
	endfunction : lbd_step_len

endpackage : lbd_pkg

// ==== src/lbd_tick_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface lbd_tick_if;
	logic [7:0] slot_idx;  // Slot within the 64 ms step
	logic       step_tick; // Last cycle of a step
	logic       restart;   // Realign the time base

	modport gen  (output slot_idx, output step_tick, input restart);
	modport core (input slot_idx, input step_tick, output restart);
endinterface : lbd_tick_if
`default_nettype wire

// ==== src/lbd_timebase.sv ====
`timescale 1ns/10ps
`default_nettype none
module lbd_timebase #(
	parameter int unsigned SLOT_CYC = lbd_pkg::SLOT_CYC_DEF
) (
	// Clock, reset, enable
	input  wire logic  sys_clk_i,
	input  wire logic  sys_rst_i,
	input  wire logic  ce_i,
	// Tick carrier
	lbd_tick_if.gen    tick
);
	import lbd_pkg::*;

	localparam int unsigned CW = (SLOT_CYC > 1) ? $clog2(SLOT_CYC) : 1;

	logic [CW-1:0] cyc_ff;    // Cycles within the slot
	logic [7:0]    slot_ff;   // Slot within the step
	logic          slot_end;  // Last cycle of a slot
	logic          step_end;  // Last cycle of a step

	assign slot_end       = (cyc_ff == CW'(SLOT_CYC - 1));
	assign step_end       = slot_end && (slot_ff == 8'(SLOTS_PER_STEP - 1));
	assign tick.slot_idx  = slot_ff;
	assign tick.step_tick = step_end;

	// Counters restart on realign or at each boundary
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cyc_ff  <= '0;
			slot_ff <= 8'h00;
		end else if (ce_i) begin
			if (tick.restart || slot_end) begin
				cyc_ff <= '0;
			end else begin
				cyc_ff <= cyc_ff + CW'(1);
			end
			if (tick.restart) begin
				slot_ff <= 8'h00;
			end else if (slot_end) begin
				slot_ff <= slot_ff + 8'h01;
			end
		end
	end

	// A step ends only after a whole slot count
	step_len_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(ce_i && !tick.restart && step_end) |=> (slot_ff == 8'h00 && cyc_ff == '0))
		else $error("step tick did not wrap the time base");

endmodule : lbd_timebase
`default_nettype wire

// ==== src/lbd_led_timing.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Repeat period is 7-bit field times 64 ms, field 0 giving 64 ms.
// - High fraction is duty plus one over 32.
// - Duty zero: 250 us high, 7.75 ms low.
// - Duty all ones: output high through the whole lit part.
// - On-time is 5-bit field times 64 ms.
// - Unused upper bits read zero, writes ignored.
// - All three registers clear on reset.
// - Period field writable to full 127 steps.
// - Other step lengths use same 64 ms timing.
module lbd_led_timing #(
	parameter int unsigned SLOT_CYC = lbd_pkg::SLOT_CYC_DEF
) (
	// Clock, reset, enable
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	// Register port
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output var  logic [7:0]  reg_rdata_o,
	// LED channel output
	output var  logic        chan_a_on_signal_o
);
	import lbd_pkg::*;

	lbd_tick_if tick ();  // Time base carrier

	logic [6:0] chan_a_repeat_period_ff; // Period in steps
	logic [4:0] chan_a_duty_code_ff;     // Duty code
	logic [4:0] chan_a_on_duration_ff;   // On-time in steps
	logic [7:0] step_ff;                 // Step within the period
	lbd_phase_t phase_ff;                // Lit or dark part of period
	logic [7:0] nxt_step;
	lbd_phase_t nxt_phase;
	logic       nxt_on;
	logic [7:0] nxt_rdata;
	logic       wr_period;               // Decoded writes
	logic       wr_duty;
	logic       wr_ondur;
	logic       period_end;              // Last step of the period
	logic [4:0] frame_slot;              // Slot within the 8 ms frame
	logic       pwm_high;                // Duty comparator

	// Time base
	lbd_timebase #(
		.SLOT_CYC (SLOT_CYC)
	) u_timebase (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.tick      (tick.gen)
	);

	// Register decode
	assign wr_period = reg_wr_i && (reg_addr_i == ADDR_REPEAT_PERIOD);
	assign wr_duty   = reg_wr_i && (reg_addr_i == ADDR_DUTY_CYCLE);
	assign wr_ondur  = reg_wr_i && (reg_addr_i == ADDR_ON_DURATION);

	// A new period value realigns the time base
	assign tick.restart = wr_period;

	// Step counter wraps after the programmed number of steps, after one step when 0 is programmed
	assign period_end = (step_ff + 8'h01) >= lbd_step_len(chan_a_repeat_period_ff);
	// A period write forces step 0 here, so the phase below sees the same step as step_ff
	assign nxt_step   = tick.restart ? 8'h00 :
		(!tick.step_tick ? step_ff : (period_end ? 8'h00 : step_ff + 8'h01));

	// Lit while the step index is below the on-time
	assign nxt_phase = (nxt_step < lbd_step_len({2'b00, chan_a_on_duration_ff})) ? PH_LIT : PH_DARK;

	// Duty: slots 0..code of 32 are high
	assign frame_slot = tick.slot_idx[4:0];
	assign pwm_high   = (frame_slot <= chan_a_duty_code_ff);

	// Output selection by phase
	always_comb begin
		case (phase_ff)
			PH_LIT:  nxt_on = pwm_high;
			PH_DARK: nxt_on = 1'b0;
			default: nxt_on = 1'b0;
		endcase
	end

	// Read mux, unused bits and unmapped addresses read zero
	assign nxt_rdata = (reg_addr_i == ADDR_REPEAT_PERIOD) ? {1'b0, chan_a_repeat_period_ff} :
		(reg_addr_i == ADDR_DUTY_CYCLE)  ? {3'b000, chan_a_duty_code_ff} :
		(reg_addr_i == ADDR_ON_DURATION) ? {3'b000, chan_a_on_duration_ff} : 8'h00;

	// Configuration registers
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			chan_a_repeat_period_ff <= PERIOD_RST;
			chan_a_duty_code_ff     <= DUTY_RST;
			chan_a_on_duration_ff   <= ONDUR_RST;
		end else if (ce_i) begin
			if (wr_period) begin
				chan_a_repeat_period_ff <= reg_wdata_i[6:0];
			end
			if (wr_duty) begin
				chan_a_duty_code_ff <= reg_wdata_i[4:0];
			end
			if (wr_ondur) begin
				chan_a_on_duration_ff <= reg_wdata_i[4:0];
			end
		end
	end

	// Read data
	// Holds until the next accepted read, so software may sample it late
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= RDATA_RST;
		end else if (ce_i && reg_rd_i) begin
			reg_rdata_o <= nxt_rdata;
		end
	end

	// Pattern position
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			step_ff  <= 8'h00;
			phase_ff <= PH_DARK;
		end else if (ce_i) begin
			step_ff  <= nxt_step;
			phase_ff <= nxt_phase;
		end
	end

	// Channel output
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			chan_a_on_signal_o <= 1'b0;
		end else if (ce_i) begin
			chan_a_on_signal_o <= nxt_on;
		end
	end

	// Checks share the system clock and, except reset_clear_a, are off while reset is held
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	// Register port request shapes
	sequence wr_period_s;
		ce_i && wr_period;
	endsequence

	sequence rd_period_s;
		ce_i && reg_rd_i && !reg_wr_i && (reg_addr_i == ADDR_REPEAT_PERIOD);
	endsequence

	sequence wr_duty_s;
		ce_i && wr_duty;
	endsequence

	sequence rd_duty_s;
		ce_i && reg_rd_i && !reg_wr_i && (reg_addr_i == ADDR_DUTY_CYCLE);
	endsequence

	// Register storage and readback, read may follow the write at once or one cycle later
	period_store_a : assert property (wr_period_s |=> chan_a_repeat_period_ff == $past(reg_wdata_i[6:0]))
		else $error("period field not stored");
	period_rdback_a : assert property (wr_period_s ##[1:2] rd_period_s |=>
		reg_rdata_o == {1'b0, chan_a_repeat_period_ff})
		else $error("period readback wrong");
	duty_store_a : assert property (wr_duty_s |=> chan_a_duty_code_ff == $past(reg_wdata_i[4:0]))
		else $error("duty field not stored");
	duty_rdback_a : assert property (wr_duty_s ##[1:2] rd_duty_s |=>
		reg_rdata_o == {3'b000, chan_a_duty_code_ff})
		else $error("duty readback wrong");
	ondur_store_a : assert property (ce_i && wr_ondur |=> chan_a_on_duration_ff == $past(reg_wdata_i[4:0]))
		else $error("on-time field not stored");
	rsvd_read_a : assert property (ce_i && reg_rd_i && (reg_addr_i != ADDR_REPEAT_PERIOD) |=>
		reg_rdata_o[7:5] == 3'b000)
		else $error("unused bits read nonzero");
	period_top_a : assert property (ce_i && reg_rd_i |=> !reg_rdata_o[7])
		else $error("unused period bit read nonzero");

	// Output shape inside the lit part
	duty_max_a : assert property (ce_i && phase_ff == PH_LIT && chan_a_duty_code_ff == 5'h1f |=>
		chan_a_on_signal_o)
		else $error("full duty output went low");
	duty_min_a : assert property (ce_i && phase_ff == PH_LIT && chan_a_duty_code_ff == 5'h00 |=>
		chan_a_on_signal_o == ($past(frame_slot) == 5'h00))
		else $error("minimum duty slot wrong");
	duty_frac_a : assert property (ce_i && phase_ff == PH_LIT |=>
		chan_a_on_signal_o == ($past(frame_slot) <= $past(chan_a_duty_code_ff)))
		else $error("duty fraction wrong");

	// Dark part, on-time window and step wrap
	dark_low_a : assert property (ce_i && phase_ff == PH_DARK |=> !chan_a_on_signal_o)
		else $error("output high outside on-time");
	lit_window_a : assert property (ce_i |=>
		(phase_ff == PH_LIT) == (step_ff < lbd_step_len({2'b00, $past(chan_a_on_duration_ff)})))
		else $error("lit phase outside on-time");
	step_range_a : assert property (ce_i && tick.step_tick && !tick.restart && period_end |=> step_ff == 8'h00)
		else $error("step counter missed period wrap");
	restart_align_a : assert property (ce_i && tick.restart |=> step_ff == 8'h00)
		else $error("period write did not realign");

	// A low clock enable freezes the pattern and the registers
	freeze_hold_a : assert property (!ce_i |=> $stable(step_ff) && $stable(chan_a_on_signal_o)
		&& $stable(reg_rdata_o) && $stable(chan_a_repeat_period_ff))
		else $error("state moved with clock enable low");

	// Reset clears the configuration, checked while reset is held
	reset_clear_a : assert property (@(posedge sys_clk_i) disable iff (1'b0) sys_rst_i |->
		(chan_a_repeat_period_ff == PERIOD_RST && chan_a_duty_code_ff == DUTY_RST
		&& chan_a_on_duration_ff == ONDUR_RST))
		else $error("registers not cleared in reset");

endmodule : lbd_led_timing
`default_nettype wire

// ==== verif/lbd_led_sink.sv ====
`timescale 1ns/10ps
`default_nettype none
// Current sink model: counts the cycles in which the LED is driven on
module lbd_led_sink (
	// Clock and control
	input  wire logic        sys_clk_i,
	input  wire logic        clr_i,
	// LED drive
	input  wire logic        led_on_i,
	output var  logic [15:0] hi_cnt_o
);
	// Lit-cycle counter, cleared on request
	always_ff @(posedge sys_clk_i) begin
		if (clr_i) begin
			hi_cnt_o <= 16'h0000;
		end else begin
			hi_cnt_o <= hi_cnt_o + {15'h0000, led_on_i};
		end
	end
endmodule : lbd_led_sink
`default_nettype wire

// ==== verif/lbd_led_timing_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module lbd_led_timing_test;
	import lbd_pkg::*;
	localparam int unsigned SC = 4; // Short slot for simulation
	logic        sys_clk_i;          // System clock
	logic        sys_rst_i;          // Reset
	logic        ce_i;               // Clock enable
	logic        reg_wr_i;           // Write strobe
	logic        reg_rd_i;           // Read strobe
	logic        clr;                // Sink counter clear
	logic [7:0]  reg_addr_i;         // Register offset
	logic [7:0]  reg_wdata_i;        // Write data
	logic [7:0]  reg_rdata_o;        // Read data
	logic        chan_a_on_signal_o; // LED on signal
	logic [15:0] hi_cnt;             // Lit cycles seen by the sink
	logic [7:0]  rv;                 // Read value
	logic [7:0]  w;                  // Written value
	int          n_mismatch = 0;     // Mismatch count
	int          compares   = 0;     // Comparison count
	int          cyc        = 0;     // Cycle counter for the timeout

	lbd_led_timing #(.SLOT_CYC(SC)) i_lbd_led_timing (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .chan_a_on_signal_o(chan_a_on_signal_o));
	lbd_led_sink i_lbd_led_sink (.sys_clk_i(sys_clk_i), .clr_i(clr), .led_on_i(chan_a_on_signal_o),
		.hi_cnt_o(hi_cnt));

	// Clock generator
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	// Timeout guard
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// Compare one value
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Register write
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// Register read, data one cycle after the taken edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(posedge sys_clk_i);
		v = reg_rdata_o;
	endtask : rd

	// Steps in one measured window
	function automatic int win(input int p);
		win = (p < 2) ? 1 : p;
	endfunction : win

	// Lit cycles in one window: lit steps, 8 frames a step, duty+1 slots a frame
	function automatic logic [15:0] exp_hi(input int p, input int o, input int d);
		int lit;
		lit = (o >= win(p)) ? win(p) : o;
		exp_hi = 16'(lit * 8 * (d + 1) * SC);
	endfunction : exp_hi

	// Program a pattern and measure one whole window at the sink
	task automatic run(input int p, input int o, input int d);
		wr(ADDR_DUTY_CYCLE, d[7:0]);
		wr(ADDR_ON_DURATION, o[7:0]);
		wr(ADDR_REPEAT_PERIOD, p[7:0]);
		repeat (4) @(posedge sys_clk_i);
		clr <= 1'b1;
		@(posedge sys_clk_i);
		clr <= 1'b0;
		repeat (win(p) * 256 * SC) @(posedge sys_clk_i);
		#1;
		chk(hi_cnt, exp_hi(p, o, d));
	endtask : run

	// Verdict and end of run
	task automatic stop_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	// Main sequence
	initial begin
		sys_rst_i   = 1'b1;
		ce_i        = 1'b1;
		reg_wr_i    = 1'b0;
		reg_rd_i    = 1'b0;
		reg_addr_i  = 8'h00;
		reg_wdata_i = 8'h00;
		clr         = 1'b1;
		void'($urandom(32'h0660));
		repeat (20) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		// Reset values, then all ones written, then unmapped offset
		for (int a = 8'h4c; a < 8'h4f; a++) begin
			rd(a[7:0], rv);
			chk({8'h00, rv}, 16'h0000);
			wr(a[7:0], 8'hff);
			rd(a[7:0], rv);
			chk({8'h00, rv}, (a == 8'h4c) ? 16'h007f : 16'h001f);
		end
		rd(8'h4f, rv);
		chk({8'h00, rv}, 16'h0000);
		// Write with the clock enable low is dropped
		ce_i <= 1'b0;
		wr(ADDR_DUTY_CYCLE, 8'h05);
		ce_i <= 1'b1;
		rd(ADDR_DUTY_CYCLE, rv);
		chk({8'h00, rv}, 16'h001f);
		// Random round trips
		repeat (4) begin
			w = 8'($urandom);
			wr(ADDR_REPEAT_PERIOD, w);
			rd(ADDR_REPEAT_PERIOD, rv);
			chk({8'h00, rv}, {8'h00, w & 8'h7f});
		end
		// Reset in mid-run clears every register again
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		for (int a = 8'h4c; a < 8'h4f; a++) begin
			rd(a[7:0], rv);
			chk({8'h00, rv}, 16'h0000);
		end
		// Duty corners, pattern corners, then random patterns
		run(0, 1, 0);
		run(0, 1, 31);
		run(2, 1, 31);
		run(3, 0, 5);
		repeat (6) run(int'($urandom % 4), int'($urandom % 4), int'($urandom % 32));
		stop_test();
	end
endmodule : lbd_led_timing_test
`default_nettype wire
